// ===== logic/acr_pkg.sv
package acr_pkg;
  localparam logic [3:0] ADDR_CTRL0 = 4'h0;
  localparam logic [3:0] ADDR_CTRL1 = 4'h1;
  localparam logic [3:0] ADDR_CTRL2 = 4'h2;
  localparam logic [3:0] ADDR_PIN_EN = 4'h3;
  localparam logic [3:0] ADDR_INT_STAT = 4'h4;
  localparam logic [3:0] ADDR_INT_MASK = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  // Control register 0 fields
  localparam int CTRL0_START_BIT = 7;
  localparam int CTRL0_BUSY_BIT = 6;
  localparam int CTRL0_POWER_BIT = 5;
  localparam int CTRL0_CHAN_LSB = 0;
  // Control register 2 fields
  localparam int CTRL2_AMP_BIT = 7;
  localparam int CTRL2_BG_BIT = 6;
  localparam int CTRL2_EXTPIN_BIT = 5;
  localparam int CTRL2_REFOUT_BIT = 4;
  // Reset values
  localparam logic [7:0] RST_CTRL0 = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_CTRL2 = 8'h00;
  localparam logic [7:0] RST_PIN_EN = 8'hFF;
  localparam logic [1:0] RST_INT = 2'h0;
  // Conversion timing in converter clocks
  localparam logic [4:0] SAMPLE_CLOCKS = 5'h04;
  localparam logic [4:0] TOTAL_CLOCKS = 5'h10;
  // Reference source codes
  localparam logic [3:0] REF_SUPPLY = 4'h0;
  localparam logic [3:0] REF_EXT_X1 = 4'h1;
  localparam logic [3:0] REF_EXT_X4 = 4'h4;
  localparam logic [3:0] REF_BG_X2 = 4'hA;
  localparam logic [3:0] REF_BG_X4 = 4'hC;
  // Reference routing to the analog core
  typedef enum logic [1:0] {
    ACR_REF_VDD = 2'b00,
    ACR_REF_EXT = 2'b01,
    ACR_REF_BG = 2'b10
  } acr_ref_t;
  typedef enum logic [1:0] {
    ACR_IDLE = 2'b00,
    ACR_ARMED = 2'b01,
    ACR_SAMPLE = 2'b10,
    ACR_CONVERT = 2'b11
  } acr_state_t;
endpackage : acr_pkg

// ===== logic/acr_clock_div.sv
`timescale 1ns/1ps
module acr_clock_div #(
  parameter int SEL_WIDTH = 3
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Control
  input wire logic i_run,
  input wire logic [SEL_WIDTH-1:0] i_select,
  // Enable out
  output logic o_tick
);
  localparam int CNT_W = (1 << SEL_WIDTH) - 1;
  initial
  begin
    if (SEL_WIDTH < 1 || SEL_WIDTH > 4)
    begin
      $error("acr_clock_div: SEL_WIDTH out of range");
    end
  end
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] nxt_count;
  logic tick_ff;
  logic nxt_tick;
  logic [CNT_W-1:0] limit;
  always_comb
  begin
    limit = CNT_W'((1 << i_select) - 1);
    nxt_count = count_ff;
    nxt_tick = 1'b0;
    if (!i_run)
    begin
      nxt_count = '0;
    end
    else if (count_ff >= limit)
    begin
      // One tick every two-power-select system clocks
      nxt_count = '0;
      nxt_tick = 1'b1;
    end
    else
    begin
      nxt_count = count_ff + CNT_W'(1);
    end
  end
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      count_ff <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      count_ff <= nxt_count;
      tick_ff <= nxt_tick;
    end
  end
  assign o_tick = tick_ff;
endmodule : acr_clock_div

// ===== logic/acr_top.sv
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module acr_top #(
  parameter int NUM_CHANNELS = 8
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Interrupt
  output logic o_irq,
  // Analog core
  output logic o_conv_power,
  output logic o_conv_clock_tick,
  output logic o_sample,
  output logic o_convert,
  output logic o_conv_done,
  output logic [2:0] o_channel,
  output logic [1:0] o_ref_source,
  output logic [2:0] o_ref_gain,
  output logic o_ref_amp_enable,
  output logic o_bandgap_enable,
  // Pin sharing
  input wire logic [NUM_CHANNELS-1:0] i_pullup_request,
  input wire logic [NUM_CHANNELS-1:0] i_port_dir_input,
  output logic [NUM_CHANNELS-1:0] o_analog_pin,
  output logic [NUM_CHANNELS-1:0] o_pullup_enable,
  output logic [NUM_CHANNELS-1:0] o_port_dir_input,
  output logic o_ext_ref_pin_analog,
  output logic o_ref_out_pin_analog,
  output logic o_ref_out_drive
);
  initial
  begin
    if (NUM_CHANNELS != 8)
    begin
      $error("acr_top: NUM_CHANNELS must be 8");
    end
  end
  // Register file
  logic start_ff, nxt_start;
  logic power_ff, nxt_power;
  logic [2:0] chan_ff, nxt_chan;
  logic [2:0] div_ff, nxt_div;
  logic [7:0] ctrl2_ff, nxt_ctrl2;
  logic [7:0] pin_en_ff, nxt_pin_en;
  logic [1:0] int_stat_ff, nxt_int_stat;
  logic [1:0] int_mask_ff, nxt_int_mask;
  logic [7:0] rdata_ff, nxt_rdata;
  logic irq_ff, nxt_irq;
  // Sequencer
  acr_pkg::acr_state_t state_ff, nxt_state;
  logic [4:0] clk_cnt_ff, nxt_clk_cnt;
  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;
  logic abort_ev;
  logic tick;
  logic tick_ff;
  // Analog outputs
  logic sample_ff, nxt_sample;
  logic convert_ff, nxt_convert;
  logic [1:0] ref_src_ff, nxt_ref_src;
  logic [2:0] ref_gain_ff, nxt_ref_gain;
  logic [NUM_CHANNELS-1:0] pin_ff, nxt_pin;
  logic [NUM_CHANNELS-1:0] pull_ff, nxt_pull;
  logic [NUM_CHANNELS-1:0] dir_ff, nxt_dir;
  logic [3:0] ref_sel;
  // Divider runs only while powered
  acr_clock_div #(
    .SEL_WIDTH(3)
  ) u_div (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_run(power_ff),
    .i_select(div_ff),
    .o_tick(tick)
  );
  assign ref_sel = ctrl2_ff[3:0];
  always_comb
  begin
    nxt_start = start_ff;
    nxt_power = power_ff;
    nxt_chan = chan_ff;
    nxt_div = div_ff;
    nxt_ctrl2 = ctrl2_ff;
    nxt_pin_en = pin_en_ff;
    nxt_int_mask = int_mask_ff;
    nxt_int_stat = int_stat_ff;
    nxt_rdata = 8'h00;
    if (i_wr)
    begin
      if (i_addr == acr_pkg::ADDR_CTRL0)
      begin
        nxt_start = i_wdata[acr_pkg::CTRL0_START_BIT];
        nxt_power = i_wdata[acr_pkg::CTRL0_POWER_BIT];
        nxt_chan = i_wdata[acr_pkg::CTRL0_CHAN_LSB +: 3];
      end
      else if (i_addr == acr_pkg::ADDR_CTRL1)
      begin
        nxt_div = i_wdata[2:0];
      end
      else if (i_addr == acr_pkg::ADDR_CTRL2)
      begin
        nxt_ctrl2 = i_wdata;
      end
      else if (i_addr == acr_pkg::ADDR_PIN_EN)
      begin
        nxt_pin_en = i_wdata;
      end
      else if (i_addr == acr_pkg::ADDR_INT_STAT)
      begin
        nxt_int_stat = int_stat_ff & ~i_wdata[1:0];
      end
      else if (i_addr == acr_pkg::ADDR_INT_MASK)
      begin
        nxt_int_mask = i_wdata[1:0];
      end
    end
    // Hardware set wins over write-one clear; flag rises as busy drops
    if (nxt_done)
    begin
      nxt_int_stat[0] = 1'b1;
    end
    if (abort_ev)
    begin
      nxt_int_stat[1] = 1'b1;
    end
    if (i_rd)
    begin
      if (i_addr == acr_pkg::ADDR_CTRL0)
      begin
        nxt_rdata = {start_ff, busy_ff, power_ff, 2'b00, chan_ff};
      end
      else if (i_addr == acr_pkg::ADDR_CTRL1)
      begin
        nxt_rdata = {5'h00, div_ff};
      end
      else if (i_addr == acr_pkg::ADDR_CTRL2)
      begin
        nxt_rdata = ctrl2_ff;
      end
      else if (i_addr == acr_pkg::ADDR_PIN_EN)
      begin
        nxt_rdata = pin_en_ff;
      end
      else if (i_addr == acr_pkg::ADDR_INT_STAT)
      begin
        nxt_rdata = {6'h00, int_stat_ff};
      end
      else if (i_addr == acr_pkg::ADDR_INT_MASK)
      begin
        nxt_rdata = {6'h00, int_mask_ff};
      end
      else if (i_addr == acr_pkg::ADDR_STATUS)
      begin
        nxt_rdata = {4'h0, busy_ff, sample_ff, state_ff};
      end
      else
      begin
        nxt_rdata = 8'h00;
      end
    end
    nxt_irq = |(nxt_int_stat & nxt_int_mask);
  end
  always_comb
  begin
    nxt_state = state_ff;
    nxt_clk_cnt = clk_cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    abort_ev = 1'b0;
    if (!power_ff)
    begin
      // No conversion without power
      nxt_state = acr_pkg::ACR_IDLE;
      nxt_busy = 1'b0;
      abort_ev = busy_ff;
    end
    else if (start_ff)
    begin
      // Start held high keeps converter in reset
      nxt_state = acr_pkg::ACR_ARMED;
      nxt_busy = 1'b0;
      nxt_clk_cnt = 5'h00;
      abort_ev = busy_ff;
    end
    else
    begin
      case (state_ff)
        acr_pkg::ACR_ARMED:
        begin
          // Falling edge after rising begins conversion
          nxt_state = acr_pkg::ACR_SAMPLE;
          nxt_busy = 1'b1;
          nxt_clk_cnt = 5'h00;
        end
        acr_pkg::ACR_SAMPLE:
        begin
          if (tick_ff)
          begin
            nxt_clk_cnt = clk_cnt_ff + 5'h01;
            if (clk_cnt_ff + 5'h01 == acr_pkg::SAMPLE_CLOCKS)
            begin
              nxt_state = acr_pkg::ACR_CONVERT;
            end
          end
        end
        acr_pkg::ACR_CONVERT:
        begin
          if (tick_ff)
          begin
            nxt_clk_cnt = clk_cnt_ff + 5'h01;
            if (clk_cnt_ff + 5'h01 == acr_pkg::TOTAL_CLOCKS)
            begin
              // Busy drops with interrupt request
              nxt_state = acr_pkg::ACR_IDLE;
              nxt_busy = 1'b0;
              nxt_done = 1'b1;
            end
          end
        end
        default:
        begin
          nxt_state = acr_pkg::ACR_IDLE;
        end
      endcase
    end
    nxt_sample = (nxt_state == acr_pkg::ACR_SAMPLE);
    nxt_convert = (nxt_state == acr_pkg::ACR_CONVERT);
  end
  always_comb
  begin
    nxt_ref_src = acr_pkg::ACR_REF_VDD;
    nxt_ref_gain = 3'h1;
    // Codes 5-9 and D-F fall back to supply; 2, 3 and B take in-between gains
    if (ref_sel >= acr_pkg::REF_EXT_X1 && ref_sel <= acr_pkg::REF_EXT_X4)
    begin
      nxt_ref_src = acr_pkg::ACR_REF_EXT;
      nxt_ref_gain = ref_sel[2:0];
    end
    else if (ref_sel >= acr_pkg::REF_BG_X2 && ref_sel <= acr_pkg::REF_BG_X4)
    begin
      nxt_ref_src = acr_pkg::ACR_REF_BG;
      nxt_ref_gain = 3'(ref_sel - 4'h8);
    end
    // Bandgap enabled beside external: bandgap only
    if (nxt_ref_src == acr_pkg::ACR_REF_EXT && ctrl2_ff[acr_pkg::CTRL2_BG_BIT])
    begin
      nxt_ref_src = acr_pkg::ACR_REF_BG;
    end
  end
  // Per-pin sharing
  genvar g;
  generate
    for (g = 0; g < NUM_CHANNELS; g++)
    begin : g_pin
      always_comb
      begin
        nxt_pin[g] = pin_en_ff[g];
        nxt_pull[g] = i_pullup_request[g] & ~pin_en_ff[g];
        nxt_dir[g] = i_port_dir_input[g] | pin_en_ff[g];
      end
    end
  endgenerate
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      start_ff <= acr_pkg::RST_CTRL0[acr_pkg::CTRL0_START_BIT];
      power_ff <= acr_pkg::RST_CTRL0[acr_pkg::CTRL0_POWER_BIT];
      chan_ff <= acr_pkg::RST_CTRL0[2:0];
      div_ff <= acr_pkg::RST_CTRL1[2:0];
      ctrl2_ff <= acr_pkg::RST_CTRL2;
      pin_en_ff <= acr_pkg::RST_PIN_EN;
      int_stat_ff <= acr_pkg::RST_INT;
      int_mask_ff <= acr_pkg::RST_INT;
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
      state_ff <= acr_pkg::ACR_IDLE;
      clk_cnt_ff <= 5'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      sample_ff <= 1'b0;
      convert_ff <= 1'b0;
      ref_src_ff <= acr_pkg::ACR_REF_VDD;
      ref_gain_ff <= 3'h1;
      pin_ff <= acr_pkg::RST_PIN_EN;
      pull_ff <= '0;
      dir_ff <= '1;
    end
    else
    begin
      start_ff <= nxt_start;
      power_ff <= nxt_power;
      chan_ff <= nxt_chan;
      div_ff <= nxt_div;
      ctrl2_ff <= nxt_ctrl2;
      pin_en_ff <= nxt_pin_en;
      int_stat_ff <= nxt_int_stat;
      int_mask_ff <= nxt_int_mask;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
      state_ff <= nxt_state;
      clk_cnt_ff <= nxt_clk_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      sample_ff <= nxt_sample;
      convert_ff <= nxt_convert;
      ref_src_ff <= nxt_ref_src;
      ref_gain_ff <= nxt_ref_gain;
      pin_ff <= nxt_pin;
      pull_ff <= nxt_pull;
      dir_ff <= nxt_dir;
    end
  end
  // Register outputs
  logic [2:0] chan_out_ff;
  logic amp_ff, bg_ff, extpin_ff, refout_ff, refdrv_ff;
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      tick_ff <= 1'b0;
      chan_out_ff <= 3'h0;
      amp_ff <= 1'b0;
      bg_ff <= 1'b0;
      extpin_ff <= 1'b0;
      refout_ff <= 1'b0;
      refdrv_ff <= 1'b0;
    end
    else
    begin
      // Gated by next phase so a pulse and the phase it counts in share a cycle
      tick_ff <= tick & (nxt_state == acr_pkg::ACR_SAMPLE || nxt_state == acr_pkg::ACR_CONVERT);
      chan_out_ff <= chan_ff;
      amp_ff <= ctrl2_ff[acr_pkg::CTRL2_AMP_BIT];
      bg_ff <= ctrl2_ff[acr_pkg::CTRL2_BG_BIT];
      extpin_ff <= ctrl2_ff[acr_pkg::CTRL2_EXTPIN_BIT];
      refout_ff <= ctrl2_ff[acr_pkg::CTRL2_REFOUT_BIT];
      // Selected reference goes out when pin function enabled and converter powered
      refdrv_ff <= ctrl2_ff[acr_pkg::CTRL2_REFOUT_BIT] & power_ff;
    end
  end
  assign o_rdata = rdata_ff;
  assign o_irq = irq_ff;
  assign o_conv_power = power_ff;
  assign o_conv_clock_tick = tick_ff;
  assign o_sample = sample_ff;
  assign o_convert = convert_ff;
  assign o_conv_done = done_ff;
  assign o_channel = chan_out_ff;
  assign o_ref_source = ref_src_ff;
  assign o_ref_gain = ref_gain_ff;
  assign o_ref_amp_enable = amp_ff;
  assign o_bandgap_enable = bg_ff;
  assign o_analog_pin = pin_ff;
  assign o_pullup_enable = pull_ff;
  assign o_port_dir_input = dir_ff;
  assign o_ext_ref_pin_analog = extpin_ff;
  assign o_ref_out_pin_analog = refout_ff;
  assign o_ref_out_drive = refdrv_ff;
endmodule : acr_top

// ===== verification/acr_core_model.sv
`timescale 1ns/1ps
module acr_core_model (
  // Clock and control
  input wire logic i_clock,
  input wire logic i_clear,
  // Converter phases
  input wire logic i_sample,
  input wire logic i_convert,
  input wire logic i_tick,
  // Tick counts per phase
  output logic [4:0] o_sample_ticks,
  output logic [4:0] o_convert_ticks
);
  // Counts only on ticks, so a slow divider shows the same totals
  always_ff @(posedge i_clock)
  begin
    if (i_clear)
    begin
      o_sample_ticks <= 5'h00;
      o_convert_ticks <= 5'h00;
    end
    else if (i_tick)
    begin
      o_sample_ticks <= o_sample_ticks + {4'h0, i_sample};
      o_convert_ticks <= o_convert_ticks + {4'h0, i_convert};
    end
  end
endmodule : acr_core_model

// ===== verification/acr_checker.sv
`timescale 1ns/1ps
module acr_checker #(
  parameter int NUM_CHANNELS = 8
) (
  // Clock, reset and bus
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  // Pins
  input wire logic [NUM_CHANNELS-1:0] i_pullup_request,
  input wire logic [NUM_CHANNELS-1:0] i_port_dir_input,
  input wire logic [NUM_CHANNELS-1:0] o_analog_pin,
  input wire logic [NUM_CHANNELS-1:0] o_pullup_enable,
  input wire logic [NUM_CHANNELS-1:0] o_port_dir_input,
  // Converter
  input wire logic o_conv_power,
  input wire logic o_conv_clock_tick,
  input wire logic o_sample,
  input wire logic o_convert,
  input wire logic o_conv_done
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);
  logic run;
  logic [2:0] div_ff;
  logic [7:0] gap_ff;
  logic [4:0] ticks_ff;
  assign run = o_sample | o_convert;
  // Gap is trusted only after a tick of the same run
  always_ff @(posedge i_clock)
  begin
    gap_ff <= o_conv_clock_tick ? 8'h00 : gap_ff + 8'h01;
    ticks_ff <= run ? ticks_ff + {4'h0, o_conv_clock_tick} : 5'h00;
    if (i_srst)
      div_ff <= 3'h0;
    else if (i_wr && i_addr == acr_pkg::ADDR_CTRL1)
      div_ff <= i_wdata[2:0];
  end
  sequence s_arm;
    i_wr && i_addr == acr_pkg::ADDR_CTRL0 && i_wdata[7] && i_wdata[5];
  endsequence
  sequence s_fire;
    i_wr && i_addr == acr_pkg::ADDR_CTRL0 && !i_wdata[7] && i_wdata[5];
  endsequence
  sequence s_quiet;
    !(i_wr && i_addr == acr_pkg::ADDR_CTRL0);
  endsequence
  a_tick_period: assert property (
    o_conv_clock_tick && run && ticks_ff != 5'h00 |-> gap_ff == (8'h01 << div_ff) - 8'h01)
    else $error("tick spacing");
  a_sample_len: assert property ($rose(o_convert) |-> ticks_ff == 5'h04)
    else $error("sample length");
  a_total_len: assert property (o_conv_done |-> ticks_ff == 5'h10)
    else $error("conversion length");
  a_power_gate: assert property (!o_conv_power && !$past(o_conv_power) |-> !run)
    else $error("run without power");
  a_start_run: assert property (s_arm ##2 s_fire |-> ##[1:3] o_sample)
    else $error("start not taken");
  a_start_hold: assert property (s_arm ##1 s_quiet [*3] |-> !run)
    else $error("held start runs");
  a_pull_drop: assert property (o_pullup_enable == ($past(i_pullup_request) & ~o_analog_pin))
    else $error("pull-high kept");
  a_dir_over: assert property (o_port_dir_input == ($past(i_port_dir_input) | o_analog_pin))
    else $error("direction kept");
  a_pin_write: assert property (
    i_wr && i_addr == acr_pkg::ADDR_PIN_EN |-> ##2 o_analog_pin == $past(i_wdata, 2))
    else $error("pin enable");
endmodule : acr_checker
bind acr_top acr_checker #(.NUM_CHANNELS(NUM_CHANNELS)) i_acr_checker (.*);

// ===== verification/test_adc_clock_reference_control.sv
`timescale 1ns/1ps
module test_adc_clock_reference_control;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic clr = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] i_pullup_request = 8'hFF;
  logic [7:0] i_port_dir_input = 8'h0F;
  logic [7:0] o_rdata, o_analog_pin, o_pullup_enable, o_port_dir_input;
  logic o_irq, o_conv_power, o_conv_clock_tick, o_sample, o_convert, o_conv_done;
  logic o_ref_amp_enable, o_bandgap_enable, o_ext_ref_pin_analog, o_ref_out_pin_analog, o_ref_out_drive;
  logic [2:0] o_channel, o_ref_gain;
  logic [1:0] o_ref_source;
  logic [4:0] st, ct;
  int mismatches = 0;
  int compares = 0;
  // Rows: write data, source, gain
  localparam logic [12:0] ROWS [10] = '{{8'h00, 2'h0, 3'h1}, {8'h01, 2'h1, 3'h1}, {8'h13, 2'h1, 3'h3},
    {8'h24, 2'h1, 3'h4}, {8'h09, 2'h0, 3'h1}, {8'h8A, 2'h2, 3'h2}, {8'h4C, 2'h2, 3'h4},
    {8'h0F, 2'h0, 3'h1}, {8'hE2, 2'h2, 3'h2}, {8'hF0, 2'h0, 3'h1}};
  always #12.5 i_clock = ~i_clock;
  acr_top i_acr_top (.*);
  acr_core_model i_acr_core_model (.i_clock(i_clock), .i_clear(clr), .i_sample(o_sample),
    .i_convert(o_convert), .i_tick(o_conv_clock_tick), .o_sample_ticks(st), .o_convert_ticks(ct));
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    chk("read data", exp, o_rdata);
  endtask : rdchk
  task automatic conv(input logic [2:0] d);
    int n;
    wr(acr_pkg::ADDR_CTRL1, {5'h00, d});
    clr <= 1'b1;
    wr(acr_pkg::ADDR_CTRL0, {5'h14, d});
    clr <= 1'b0;
    wr(acr_pkg::ADDR_CTRL0, {5'h04, d});
    for (n = 0; n < 5000 && o_conv_done !== 1'b1; n++)
      @(negedge i_clock);
    chk("done seen", 8'h01, {7'h00, o_conv_done});
    if (n == 5000)
      end_of_test();
    chk("channel", {5'h00, d}, {5'h00, o_channel});
    chk("sample ticks", 8'h04, {3'h0, st});
    chk("convert ticks", 8'h0C, {3'h0, ct});
  endtask : conv
  initial
  begin
    repeat (8) @(posedge i_clock);
    i_srst <= 1'b0;
    @(negedge i_clock);
    chk("pin reset", 8'hFF, o_analog_pin);
    chk("dir reset", 8'hFF, o_port_dir_input);
    chk("pull reset", 8'h00, o_pullup_enable);
    rdchk(acr_pkg::ADDR_PIN_EN, 8'hFF);
    wr(4'h7, 8'h55);
    rdchk(4'h7, 8'h00);
    wr(acr_pkg::ADDR_PIN_EN, 8'h5A);
    repeat (2) @(negedge i_clock);
    chk("pin", 8'h5A, o_analog_pin);
    chk("pull", 8'hA5, o_pullup_enable);
    chk("dir", 8'h5F, o_port_dir_input);
    wr(acr_pkg::ADDR_CTRL0, 8'h20);
    repeat (20) @(posedge i_clock);
    foreach (ROWS[i])
    begin
      wr(acr_pkg::ADDR_CTRL2, ROWS[i][12:5]);
      repeat (2) @(negedge i_clock);
      chk("source", {6'h00, ROWS[i][4:3]}, {6'h00, o_ref_source});
      chk("gain", {5'h00, ROWS[i][2:0]}, {5'h00, o_ref_gain});
      chk("ref bits", {4'h0, ROWS[i][12:9]},
        {4'h0, o_ref_amp_enable, o_bandgap_enable, o_ext_ref_pin_analog, o_ref_out_pin_analog});
      chk("ref drive", {7'h00, ROWS[i][9]}, {7'h00, o_ref_out_drive});
      rdchk(acr_pkg::ADDR_CTRL2, ROWS[i][12:5]);
    end
    for (int d = 0; d < 8; d++)
      conv(3'(d));
    wr(acr_pkg::ADDR_INT_MASK, 8'h01);
    repeat (2) @(negedge i_clock);
    chk("irq", 8'h01, {7'h00, o_irq});
    wr(acr_pkg::ADDR_INT_STAT, 8'h01);
    repeat (2) @(negedge i_clock);
    chk("irq cleared", 8'h00, {7'h00, o_irq});
    wr(acr_pkg::ADDR_CTRL0, 8'hA3);
    wr(acr_pkg::ADDR_CTRL0, 8'h23);
    rdchk(acr_pkg::ADDR_CTRL0, 8'h63);
    wr(acr_pkg::ADDR_CTRL0, 8'hA3);
    repeat (4) @(negedge i_clock);
    chk("aborted", 8'h00, {7'h00, o_sample | o_convert});
    rdchk(acr_pkg::ADDR_CTRL0, 8'hA3);
    rdchk(acr_pkg::ADDR_INT_STAT, 8'h02);
    chk("abort masked", 8'h00, {7'h00, o_irq});
    wr(acr_pkg::ADDR_CTRL0, 8'h80);
    wr(acr_pkg::ADDR_CTRL0, 8'h00);
    repeat (40) @(negedge i_clock);
    chk("unpowered", 8'h00, {6'h00, o_conv_power, o_sample | o_convert});
    end_of_test();
  end
endmodule : test_adc_clock_reference_control
